// *** hw/vbs_timing.sv ***
// Vertical blank timing, AC modulation and start address registers
//
// Operation
// - Vertical register top bit reads one during vertical blank, else zero.
// - Rate zero: AC modulation output inverts on every frame pulse.
// - Nonzero rate N: AC modulation output inverts every N+1 line pulses.
// - Modulation only works for passive panels; held low for active-matrix.
// - Screen one start address is sixteen bits in a low and high byte.
// - Landscape: screen one start address is a word address.
// - Rotated: screen one start address is a byte address.
// - Rotated: a separate register supplies start address bit sixteen.
// - The extra start address bit is ignored in landscape orientation.
// - Screen two start address is used in landscape only, ignored rotated.
`timescale 1ns/1ps
`default_nettype none
module vbs_timing
    import vbs_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Panel side and fetch side
    output var vbs_panel_t panel,
    output var vbs_addr_t start_addr,
    // Interrupt
    output logic irq
);
    // Register file
    logic [5:0] vblank_period_reg;
    logic [5:0] ac_toggle_interval_reg;
    logic [7:0] s1_low_reg;
    logic [7:0] s1_high_reg;
    logic s1_bit16_reg;
    logic [7:0] s2_low_reg;
    logic [7:0] s2_high_reg;
    logic [2:0] ctrl_reg;
    logic [9:0] active_lines_reg;
    logic [15:0] line_clocks_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    // Bus state
    logic aw_got_reg, w_got_reg;
    logic [31:0] awaddr_reg, wdata_reg;
    logic wstrb0_reg;
    logic wr_fire, rd_fire;
    logic [19:0] wr_idx, rd_idx;
    logic wr_hit, rd_hit;
    logic [31:0] rd_data;
    // Timing state
    vbs_vstate_t vstate_reg, vstate_next;
    logic [15:0] pix_cnt_reg;
    logic [10:0] line_cnt_reg, line_next;
    logic [10:0] total_lines;
    logic [15:0] pix_last;
    logic line_tick, frame_tick, blank_entry;
    logic [5:0] mod_cnt_reg;
    logic frame_pulse_reg, line_pulse_reg, ac_mod_reg, vblank_reg;
    logic [1:0] irq_events, irq_stat_next;
    logic en, rot, passive;

    assign en = ctrl_reg[VBS_CTRL_EN_BIT];
    assign rot = ctrl_reg[VBS_CTRL_ROT_BIT];
    assign passive = ctrl_reg[VBS_CTRL_PASSIVE_BIT];

    // Register index from byte address; misaligned addresses never hit
    assign wr_idx = awaddr_reg[21:2];
    assign rd_idx = s_axi_araddr[21:2];
    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Write channel capture: address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= VBS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? VBS_RESP_OKAY : VBS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Address decode of the writable map
    always_comb begin
        wr_hit = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg[31:22] == 10'h000);
        case (wr_idx)
            VBS_IDX_VERT, VBS_IDX_MOD, VBS_IDX_S1_LO, VBS_IDX_S1_HI,
            VBS_IDX_S2_LO, VBS_IDX_S2_HI, VBS_IDX_S1_B16, VBS_IDX_CTRL,
            VBS_IDX_LINES, VBS_IDX_LCLK, VBS_IDX_ISTAT,
            VBS_IDX_IMASK: ;
            default: wr_hit = 1'b0;
        endcase
    end

    // Register writes gated by the lane zero strobe alone; line count and line length also store lane one data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vblank_period_reg <= VBS_RST_VERT;
            ac_toggle_interval_reg <= VBS_RST_MOD;
            s1_low_reg <= VBS_RST_BYTE;
            s1_high_reg <= VBS_RST_BYTE;
            s1_bit16_reg <= 1'b0;
            s2_low_reg <= VBS_RST_BYTE;
            s2_high_reg <= VBS_RST_BYTE;
            ctrl_reg <= VBS_RST_CTRL;
            active_lines_reg <= VBS_RST_LINES;
            line_clocks_reg <= VBS_RST_LCLK;
            irq_mask_reg <= VBS_RST_IRQ;
        end else if (wr_fire && wr_hit && wstrb0_reg) begin
            case (wr_idx)
                // Status and unused bit are dropped on write
                VBS_IDX_VERT: vblank_period_reg <= wdata_reg[5:0];
                VBS_IDX_MOD: ac_toggle_interval_reg <= wdata_reg[5:0];
                VBS_IDX_S1_LO: s1_low_reg <= wdata_reg[7:0];
                VBS_IDX_S1_HI: s1_high_reg <= wdata_reg[7:0];
                VBS_IDX_S2_LO: s2_low_reg <= wdata_reg[7:0];
                VBS_IDX_S2_HI: s2_high_reg <= wdata_reg[7:0];
                VBS_IDX_S1_B16: s1_bit16_reg <= wdata_reg[0];
                VBS_IDX_CTRL: ctrl_reg <= wdata_reg[2:0];
                VBS_IDX_LINES: active_lines_reg <= wdata_reg[9:0];
                VBS_IDX_LCLK: line_clocks_reg <= wdata_reg[15:0];
                VBS_IDX_IMASK: irq_mask_reg <= wdata_reg[1:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped or misaligned answers SLVERR with zero data
    always_comb begin
        rd_hit = (s_axi_araddr[1:0] == 2'h0) &&
                 (s_axi_araddr[31:22] == 10'h000);
        rd_data = 32'h0000_0000;
        case (rd_idx)
            VBS_IDX_VERT: begin
                rd_data[5:0] = vblank_period_reg;
                rd_data[VBS_VERT_STAT_BIT] = panel.vblank;
            end
            VBS_IDX_MOD: rd_data[5:0] = ac_toggle_interval_reg;
            VBS_IDX_S1_LO: rd_data[7:0] = s1_low_reg;
            VBS_IDX_S1_HI: rd_data[7:0] = s1_high_reg;
            VBS_IDX_S2_LO: rd_data[7:0] = s2_low_reg;
            VBS_IDX_S2_HI: rd_data[7:0] = s2_high_reg;
            VBS_IDX_S1_B16: rd_data[0] = s1_bit16_reg;
            VBS_IDX_CTRL: rd_data[2:0] = ctrl_reg;
            VBS_IDX_LINES: rd_data[9:0] = active_lines_reg;
            VBS_IDX_LCLK: rd_data[15:0] = line_clocks_reg;
            VBS_IDX_ISTAT: rd_data[1:0] = irq_stat_reg;
            VBS_IDX_IMASK: rd_data[1:0] = irq_mask_reg;
            default: rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_data = 32'h0000_0000;
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= VBS_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? VBS_RESP_OKAY : VBS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Line and frame ticks; a zero line length behaves as one clock
    assign pix_last = (line_clocks_reg == 16'h0000) ? 16'h0000 :
                      line_clocks_reg - 16'h0001;
    assign total_lines = {1'b0, active_lines_reg} + {5'h00, vblank_period_reg};
    assign line_tick = en && (pix_cnt_reg >= pix_last);
    assign frame_tick = line_tick && (line_cnt_reg + 11'h001 >= total_lines);
    assign line_next = frame_tick ? 11'h000 : line_cnt_reg + 11'h001;

    // Blank covers exactly the lines past the active count, no offset
    always_comb begin
        vstate_next = vstate_reg;
        if (line_tick) begin
            vstate_next = (line_next >= {1'b0, active_lines_reg}) ?
                          VBS_BLANK : VBS_ACTIVE;
        end
        case (vstate_reg)
            VBS_ACTIVE: blank_entry = line_tick && (vstate_next == VBS_BLANK);
            VBS_BLANK: blank_entry = 1'b0;
            default: blank_entry = 1'b0;
        endcase
    end

    // Pixel, line and vertical state counters; parked while disabled
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            pix_cnt_reg <= 16'h0000;
            line_cnt_reg <= 11'h000;
            vstate_reg <= VBS_ACTIVE;
        end else begin
            pix_cnt_reg <= line_tick ? 16'h0000 : pix_cnt_reg + 16'h0001;
            if (line_tick) begin
                line_cnt_reg <= line_next;
            end
            vstate_reg <= vstate_next;
        end
    end

    // Panel strobes and status flag, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_pulse_reg <= 1'b0;
            line_pulse_reg <= 1'b0;
            vblank_reg <= 1'b0;
        end else begin
            frame_pulse_reg <= frame_tick;
            line_pulse_reg <= line_tick;
            vblank_reg <= en && (vstate_next == VBS_BLANK);
        end
    end
    // One flop per field, so the bundle has a single driver
    assign panel = {frame_pulse_reg, line_pulse_reg, ac_mod_reg, vblank_reg};

    // AC modulation; rate is compared live, so a change applies to the running count
    always_ff @(posedge aclk) begin
        if (!aresetn || !passive) begin
            ac_mod_reg <= 1'b0;
            mod_cnt_reg <= 6'h00;
        end else if (ac_toggle_interval_reg == 6'h00) begin
            mod_cnt_reg <= 6'h00;
            if (frame_tick) begin
                ac_mod_reg <= !ac_mod_reg;
            end
        end else if (line_tick) begin
            if (mod_cnt_reg >= ac_toggle_interval_reg) begin
                mod_cnt_reg <= 6'h00;
                ac_mod_reg <= !ac_mod_reg;
            end else begin
                mod_cnt_reg <= mod_cnt_reg + 6'h01;
            end
        end
    end

    // Start addresses follow the registers while disabled and are sampled at frame start while enabled, to avoid mid-frame tearing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_addr <= '0;
        end else if (frame_tick || !en) begin
            // Bit sixteen only counts in rotated byte addressing
            start_addr.s1_addr <= {rot & s1_bit16_reg,
                                   s1_high_reg, s1_low_reg};
            start_addr.s1_byte_mode <= rot;
            start_addr.s2_addr <= {s2_high_reg, s2_low_reg};
            start_addr.s2_enable <= !rot;
        end
    end

    // Sticky events, cleared by a status read; a new event wins the clear
    assign irq_events[VBS_IRQ_FRAME_BIT] = frame_tick;
    assign irq_events[VBS_IRQ_BLANK_BIT] = blank_entry;
    assign irq_stat_next = ((rd_fire && rd_hit && rd_idx == VBS_IDX_ISTAT) ?
                            2'h0 : irq_stat_reg) | irq_events;

    // Interrupt status and level output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= VBS_RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    blank_entry_line_a: assert property (
        $rose(panel.vblank) |-> line_cnt_reg == {1'b0, active_lines_reg})
        else $error("blank flag rose off the active line count");
    blank_length_a: assert property (
        frame_tick |-> line_cnt_reg + 11'h001 == total_lines)
        else $error("frame wrapped before blank period ended");
    mod_frame_a: assert property (
        (passive && ac_toggle_interval_reg == 6'h00 && $past(passive)
         && $past(ac_toggle_interval_reg) == 6'h00 && $changed(panel.ac_mod))
        |-> $past(frame_tick))
        else $error("modulation toggled without a frame");
    mod_lines_a: assert property (
        (passive && $past(passive) && $past(ac_toggle_interval_reg) != 6'h00
         && $changed(panel.ac_mod)) |->
        $past(line_tick && mod_cnt_reg == ac_toggle_interval_reg))
        else $error("modulation toggled off its line interval");
    mod_active_a: assert property (!passive |=> !panel.ac_mod)
        else $error("modulation active on active-matrix panel");
    start_hold_a: assert property (
        (en && !frame_tick) |=> $stable(start_addr))
        else $error("start address changed mid-frame");
    bit16_gate_a: assert property (
        (frame_tick && !rot) |=> !start_addr.s1_addr[16]
                                  && !start_addr.s1_byte_mode)
        else $error("bit sixteen used in landscape");
    s2_rotated_a: assert property (
        (frame_tick && rot) |=> !start_addr.s2_enable)
        else $error("screen two enabled in rotated mode");
    vert_write_a: assert property (
        (wr_fire && wr_hit && wstrb0_reg && wr_idx == VBS_IDX_VERT) |=>
        vblank_period_reg == $past(wdata_reg[5:0]))
        else $error("blank period write not stored");

    frame_seen_c: cover property (panel.frame_pulse ##1 !panel.frame_pulse);
    blank_seen_c: cover property ($rose(panel.vblank) ##[1:20] !panel.vblank);
    irq_seen_c: cover property ($rose(irq));
endmodule // vbs_timing
`default_nettype wire

// *** hw/vbs_pkg.sv ***
// Package: register map, field layout, reset values and types of the block
package vbs_pkg;
    // Printed register indices; the AXI byte address is four times the index
    localparam logic [19:0] VBS_IDX_VERT = 20'h1ffea;
    localparam logic [19:0] VBS_IDX_MOD = 20'h1ffeb;
    localparam logic [19:0] VBS_IDX_S1_LO = 20'h1ffec;
    localparam logic [19:0] VBS_IDX_S1_HI = 20'h1ffed;
    localparam logic [19:0] VBS_IDX_S2_LO = 20'h1ffee;
    localparam logic [19:0] VBS_IDX_S2_HI = 20'h1ffef;
    localparam logic [19:0] VBS_IDX_S1_B16 = 20'h1fff0;
    // Block control, timing and interrupt registers
    localparam logic [19:0] VBS_IDX_CTRL = 20'h1fff8;
    localparam logic [19:0] VBS_IDX_LINES = 20'h1fff9;
    localparam logic [19:0] VBS_IDX_LCLK = 20'h1fffa;
    localparam logic [19:0] VBS_IDX_ISTAT = 20'h1fffb;
    localparam logic [19:0] VBS_IDX_IMASK = 20'h1fffc;
    // Field positions
    localparam int VBS_VERT_STAT_BIT = 7;
    localparam int VBS_CTRL_EN_BIT = 0;
    localparam int VBS_CTRL_ROT_BIT = 1;
    localparam int VBS_CTRL_PASSIVE_BIT = 2;
    localparam int VBS_IRQ_FRAME_BIT = 0;
    localparam int VBS_IRQ_BLANK_BIT = 1;
    // Reset values
    localparam logic [5:0] VBS_RST_VERT = 6'h00;
    localparam logic [5:0] VBS_RST_MOD = 6'h00;
    localparam logic [7:0] VBS_RST_BYTE = 8'h00;
    localparam logic [2:0] VBS_RST_CTRL = 3'h0;
    localparam logic [9:0] VBS_RST_LINES = 10'h0f0;
    localparam logic [15:0] VBS_RST_LCLK = 16'h0100;
    localparam logic [1:0] VBS_RST_IRQ = 2'h0;
    // AXI responses
    localparam logic [1:0] VBS_RESP_OKAY = 2'h0;
    localparam logic [1:0] VBS_RESP_SLVERR = 2'h2;

    // Vertical state, one-hot
    typedef enum logic [1:0] {
        VBS_ACTIVE = 2'b01,
        VBS_BLANK = 2'b10
    } vbs_vstate_t;

    // Strobes and levels towards the panel
    typedef struct packed {
        logic frame_pulse;
        logic line_pulse;
        logic ac_mod;
        logic vblank;
    } vbs_panel_t;

    // Frame-sampled start addresses towards the fetch logic
    typedef struct packed {
        logic [16:0] s1_addr;
        logic s1_byte_mode;
        logic [15:0] s2_addr;
        logic s2_enable;
    } vbs_addr_t;
endpackage

// *** testbench/vbs_panel_model.sv ***
// Passive panel model that measures frame, blank and modulation timing
`timescale 1ns/1ps
`default_nettype none
module vbs_panel_model
    import vbs_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Strobes and levels from the controller
    input wire vbs_panel_t panel
);
    int frame_lines = 0;
    int blank_clks = 0;
    int fr_cnt = 0;
    int ln_cnt = 0;
    int bl_cnt = 0;
    int ivl[$];
    logic ac_last = 1'b0;

    // Counts include the pulse seen at the same edge as the event
    always @(posedge aclk) begin
        fr_cnt += int'(panel.line_pulse);
        ln_cnt += int'(panel.line_pulse);
        if (panel.frame_pulse) begin
            frame_lines = fr_cnt;
            fr_cnt = 0;
        end
        // A panel only sees blank length as time between edges
        if (panel.vblank) begin
            bl_cnt++;
        end else if (bl_cnt != 0) begin
            blank_clks = bl_cnt;
            bl_cnt = 0;
        end
        if (panel.ac_mod !== ac_last) begin
            ivl.push_back(ln_cnt);
            ln_cnt = 0;
        end
        ac_last = panel.ac_mod;
    end
endmodule // vbs_panel_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the vertical blank and start address block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vbs_pkg::*;
    localparam int LCLK = 16;
    localparam int LINES = 6;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    vbs_panel_t panel;
    vbs_addr_t start_addr;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [1:0] wresp = 2'h0;
    // Bench copy of the byte registers
    logic [19:0] regs [7] = '{VBS_IDX_VERT, VBS_IDX_MOD, VBS_IDX_S1_LO,
        VBS_IDX_S1_HI, VBS_IDX_S2_LO, VBS_IDX_S2_HI, VBS_IDX_S1_B16};
    logic [7:0] msk [7] = '{8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01};
    logic [7:0] cur [7];

    vbs_timing i_vbs_timing (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .panel(panel), .start_addr(start_addr),
        .irq(irq));
    vbs_panel_model i_vbs_panel_model (.aclk(aclk), .aresetn(aresetn),
        .panel(panel));

    // Clock at 100 MHz
    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    task automatic chk_vec(input logic [34:0] g, input logic [34:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_cnt(input int g, input int e);
        samples_checked++;
        if (g != e) begin
            err_count++;
            $display("mismatch at %0t: count %0d want %0d", $time, g, e);
        end
    endtask

    // Write: both channels offered together, each released when taken
    task automatic wr(input logic [19:0] idx, input logic [31:0] d);
        bit a;
        bit w;
        @(posedge aclk);
        awaddr <= {10'h0, idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        a = 0;
        w = 0;
        while (!(a && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                a = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        wresp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= {10'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [19:0] idx, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk_vec({3'h0, d}, {3'h0, e});
    endtask

    // Expected start address outputs from the bench copy
    function automatic logic [34:0] exp_addr(input bit rot);
        return {rot & cur[6][0], cur[3], cur[2], rot, cur[5], cur[4], !rot};
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [34:0] m;
        logic [34:0] pre;
        int p;
        int rate;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        void'($urandom(32'h2ee37eda));
        // Reset values, then an unmapped read
        for (int i = 0; i < 7; i++) rchk(regs[i], 32'h0);
        rd(20'h00010, d, r);
        chk_vec({3'h0, d}, 35'h0);
        chk_vec({33'h0, r}, {33'h0, VBS_RESP_SLVERR});
        wr(20'h00010, 32'hff);
        chk_vec({33'h0, wresp}, {33'h0, VBS_RESP_SLVERR});
        // Random bytes; status and unused bits must not store
        for (int i = 0; i < 7; i++) begin
            cur[i] = 8'($urandom);
            wr(regs[i], {24'h0, cur[i]});
            chk_vec({33'h0, wresp}, {33'h0, VBS_RESP_OKAY});
            cur[i] = cur[i] & msk[i];
            rchk(regs[i], {24'h0, cur[i]});
        end
        // Blank length, status bit and modulation rates on a passive panel
        for (int k = 0; k < 3; k++) begin
            p = 1 + $urandom % 8;
            rate = (k == 2) ? 3 + $urandom % 4 : k;
            wr(VBS_IDX_CTRL, 32'h0);
            wr(VBS_IDX_VERT, 32'(p));
            wr(VBS_IDX_MOD, 32'(rate));
            wr(VBS_IDX_LINES, 32'(LINES));
            wr(VBS_IDX_LCLK, 32'(LCLK));
            i_vbs_panel_model.ivl.delete();
            wr(VBS_IDX_CTRL, 32'h5); // enable, passive panel
            repeat (4) @(posedge aclk iff panel.frame_pulse);
            @(posedge aclk iff panel.vblank);
            rchk(VBS_IDX_VERT, 32'(p) | 32'h80);
            @(posedge aclk iff !panel.vblank);
            rchk(VBS_IDX_VERT, 32'(p));
            chk_cnt(i_vbs_panel_model.blank_clks, p * LCLK);
            chk_cnt(i_vbs_panel_model.frame_lines, LINES + p);
            chk_cnt(i_vbs_panel_model.ivl[$],
                (rate == 0) ? LINES + p : rate + 1);
            chk_vec({34'h0, irq}, 35'h0);
        end
        // Active-matrix panel: modulation output stays quiet
        wr(VBS_IDX_CTRL, 32'h1);
        // The forced-low step lands two edges later; let the model see it
        repeat (2) @(posedge aclk);
        i_vbs_panel_model.ivl.delete();
        repeat (3) @(posedge aclk iff panel.frame_pulse);
        chk_cnt(i_vbs_panel_model.ivl.size(), 0);
        chk_vec({34'h0, panel.ac_mod}, 35'h0);
        // Start addresses in landscape, then rotated
        for (int rot = 0; rot < 2; rot++) begin
            m = rot ? 35'h7fffe0001 : 35'h7ffffffff;
            wr(VBS_IDX_CTRL, 32'(1 + 2 * rot));
            @(posedge aclk iff panel.frame_pulse);
            #1;
            chk_vec(start_addr & m, exp_addr(rot) & m);
            pre = exp_addr(rot);
            for (int i = 2; i < 7; i++) begin
                cur[i] = 8'($urandom) & msk[i];
                wr(regs[i], {24'h0, cur[i]});
            end
            chk_vec(start_addr & m, pre & m);
            @(posedge aclk iff panel.frame_pulse);
            #1;
            chk_vec(start_addr & m, exp_addr(rot) & m);
        end
        // Interrupt: clear, unmask frame event, raise, read to clear
        wr(VBS_IDX_CTRL, 32'h0);
        rd(VBS_IDX_ISTAT, d, r);
        rchk(VBS_IDX_ISTAT, 32'h0);
        wr(VBS_IDX_IMASK, 32'h1);
        wr(VBS_IDX_CTRL, 32'h1);
        @(posedge aclk iff panel.frame_pulse);
        repeat (2) @(posedge aclk);
        chk_vec({34'h0, irq}, 35'h1);
        wr(VBS_IDX_CTRL, 32'h0);
        rchk(VBS_IDX_ISTAT, 32'h3);
        repeat (3) @(posedge aclk);
        chk_vec({34'h0, irq}, 35'h0);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
